/* File: rtl/cse_regs.vh */
// Register offsets, fields, reset values and constants for the checksum unit
`ifndef CSE_REGS_VH
`define CSE_REGS_VH
`define CSE_CTRL_ADDR 4'h0
`define CSE_DATA_ADDR 4'h4
`define CSE_RESULT_ADDR 4'h8
`define CSE_AUTO_ADDR 4'hC
`define CSE_CTRL_WIDTH32_BIT 0
`define CSE_CTRL_SEED_ONES_BIT 1
`define CSE_CTRL_REVERSE_BIT 2
`define CSE_CTRL_INIT_BIT 3
`define CSE_CTRL_BUSY_BIT 4
`define CSE_CTRL_RESET 3'h0
`define CSE_POLY16 16'h1021
`define CSE_POLY32 32'h04C11DB7
`define CSE_SEED_ZERO 32'h00000000
`define CSE_SEED_ONES 32'hFFFFFFFF
`define CSE_BLOCK_BYTES 11'h400
`define CSE_BLOCK_AW 10
`define CSE_FLASH_AW 16
`define CSE_FIFO_DEPTH 4
`define CSE_FIFO_AW 2
`define CSE_RESP_OKAY 2'h0
`define CSE_RESP_SLVERR 2'h2
`endif

/* File: rtl/cse_fifo.v */
// Small synchronous FIFO with valid and ready on both sides
`timescale 1ns/10ps
module cse_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 4,
    parameter AW = 2
) (
    input wire clk_in,
    input wire sys_rst_in,
    input wire flush_in,
    input wire in_valid_in,
    output wire in_ready_out,
    input wire [WIDTH-1:0] in_data_in,
    output wire out_valid_out,
    input wire out_ready_in,
    output wire [WIDTH-1:0] out_data_out
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr;
    reg [AW-1:0] rd_ptr;
    reg [AW:0] count;
    wire push;
    wire pop;
    assign in_ready_out = (count != DEPTH[AW:0]);
    assign out_valid_out = (count != {(AW+1){1'b0}});
    assign out_data_out = mem[rd_ptr];
    assign push = in_valid_in & in_ready_out;
    assign pop = out_valid_out & out_ready_in;
    always @(posedge clk_in) begin
        if (push) begin
            mem[wr_ptr] <= in_data_in;
        end
    end
    always @(posedge clk_in) begin
        if (sys_rst_in || flush_in) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + {{(AW-1){1'b0}}, 1'b1};
            end
            if (pop) begin
                rd_ptr <= rd_ptr + {{(AW-1){1'b0}}, 1'b1};
            end
            if (push && !pop) begin
                count <= count + {{AW{1'b0}}, 1'b1};
            end else if (pop && !push) begin
                count <= count - {{AW{1'b0}}, 1'b1};
            end
        end
    end
endmodule // cse_fifo

/* File: rtl/cse_checksum_unit.v */
// Byte-wide CRC16/CRC32 engine with AXI4-Lite registers and flash auto mode
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/10ps
`include "cse_regs.vh"
// Notes on behaviour
// R1: A control bit picks a 16-bit or a 32-bit checksum polynomial.
// R2: Each update step takes one byte and the result register is readable.
// R3: The 16-bit width uses polynomial 0x1021.
// R4: The 32-bit width uses polynomial 0x04C11DB7.
// R5: An init command seeds the checksum with all zeros or all ones.
// R6: Auto mode reads flash itself over one or more 1024-byte blocks.
// R7: An option reverses bits of each input byte and each result byte read.
module cse_checksum_unit (
    input wire clk_in,
    input wire sys_rst_in,
    input wire [3:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output wire [1:0] s_axi_bresp,
    output wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [3:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output wire [31:0] s_axi_rdata,
    output wire [1:0] s_axi_rresp,
    output wire s_axi_rvalid,
    input wire s_axi_rready,
    output reg [15:0] flash_addr_out,
    output reg flash_rd_out,
    input wire [7:0] flash_data_in,
    input wire flash_ack_in
);
    localparam ST_IDLE = 2'h0;
    localparam ST_REQ = 2'h1;
    localparam ST_WAIT = 2'h2;
    reg width32;
    reg seed_ones;
    reg reverse;
    reg [31:0] crc;
    reg [1:0] state;
    reg [5:0] block_base;
    reg [5:0] blocks_left;
    reg [9:0] byte_idx;
    reg aw_held;
    reg w_held;
    reg [3:0] aw_addr;
    reg [31:0] w_data;
    reg [3:0] w_strb;
    reg b_valid;
    reg [1:0] b_resp;
    reg r_valid;
    reg [31:0] r_data;
    reg [1:0] r_resp;
    reg sw_push;
    reg [7:0] sw_byte;
    reg auto_push;
    reg [7:0] auto_byte;
    reg init_req;
    wire fifo_in_valid;
    wire fifo_in_ready;
    wire [7:0] fifo_in_data;
    wire fifo_out_valid;
    wire [7:0] fifo_out_data;
    wire do_write;
    wire busy;
    wire [7:0] in_byte;
    wire [31:0] poly;
    wire [31:0] seed;
    reg [31:0] next_crc;
    reg fb;
    integer i;
    // Bit reversal within each result byte for reads
    wire [31:0] crc_view;
    wire [31:0] crc_rev;
    genvar g;
    generate
        for (g = 0; g < 32; g = g + 1) begin : g_rev
            assign crc_rev[g] = crc[(g & 24) + 7 - (g & 7)]; // see R7
        end
    endgenerate
    assign crc_view = reverse ? crc_rev : crc; // see R7
    // Busy also covers the idle cycle between two auto blocks
    assign busy = (state != ST_IDLE) || (blocks_left != 6'h00);
    // Write channel: address and data accepted in either order
    assign s_axi_awready = !aw_held && !b_valid;
    assign s_axi_wready = !w_held && !b_valid;
    assign s_axi_bvalid = b_valid;
    assign s_axi_bresp = b_resp;
    assign s_axi_arready = !r_valid;
    assign s_axi_rvalid = r_valid;
    assign s_axi_rdata = r_data;
    assign s_axi_rresp = r_resp;
    assign do_write = aw_held && w_held && !b_valid;
    always @(posedge clk_in) begin
        if (sys_rst_in) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 4'h0;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end else if (do_write) begin
                aw_held <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end else if (do_write) begin
                w_held <= 1'b0;
            end
        end
    end
    // Register writes and write response
    always @(posedge clk_in) begin
        if (sys_rst_in) begin
            b_valid <= 1'b0;
            b_resp <= `CSE_RESP_OKAY;
            width32 <= 1'b0;
            seed_ones <= 1'b0;
            reverse <= 1'b0;
            init_req <= 1'b0;
            sw_push <= 1'b0;
            sw_byte <= 8'h00;
            block_base <= 6'h00;
            blocks_left <= 6'h00;
        end else begin
            init_req <= 1'b0;
            if (sw_push && fifo_in_ready && !auto_push) begin
                sw_push <= 1'b0;
            end
            if (state == ST_IDLE && blocks_left != 6'h00) begin
                blocks_left <= blocks_left - 6'h01;
                // Next block follows the one now starting
                block_base <= block_base + 6'h01; // see R6
            end
            if (b_valid && s_axi_bready) begin
                b_valid <= 1'b0;
            end
            if (do_write) begin
                b_valid <= 1'b1;
                b_resp <= `CSE_RESP_OKAY;
                if (aw_addr == `CSE_CTRL_ADDR) begin
                    if (w_strb[0] && !busy) begin
                        width32 <= w_data[`CSE_CTRL_WIDTH32_BIT]; // see R1
                        seed_ones <= w_data[`CSE_CTRL_SEED_ONES_BIT];
                        reverse <= w_data[`CSE_CTRL_REVERSE_BIT];
                        init_req <= w_data[`CSE_CTRL_INIT_BIT]; // see R5
                    end
                end else if (aw_addr == `CSE_DATA_ADDR) begin
                    if (w_strb[0] && !sw_push && !busy) begin
                        sw_push <= 1'b1; // see R2
                        sw_byte <= w_data[7:0];
                    end else begin
                        b_resp <= `CSE_RESP_SLVERR;
                    end
                end else if (aw_addr == `CSE_AUTO_ADDR) begin
                    if (w_strb[0] && w_strb[1] && !busy &&
                            w_data[13:8] != 6'h00) begin
                        block_base <= w_data[5:0]; // see R6
                        blocks_left <= w_data[13:8];
                    end
                end else if (aw_addr != `CSE_RESULT_ADDR) begin
                    b_resp <= `CSE_RESP_SLVERR;
                end
            end
        end
    end
    // Read channel
    always @(posedge clk_in) begin
        if (sys_rst_in) begin
            r_valid <= 1'b0;
            r_data <= 32'h00000000;
            r_resp <= `CSE_RESP_OKAY;
        end else if (r_valid) begin
            if (s_axi_rready) begin
                r_valid <= 1'b0;
            end
        end else if (s_axi_arvalid) begin
            r_valid <= 1'b1;
            r_resp <= `CSE_RESP_OKAY;
            if (s_axi_araddr == `CSE_CTRL_ADDR) begin
                r_data <= {27'h0000000, busy, 1'b0, reverse, seed_ones,
                    width32};
            end else if (s_axi_araddr == `CSE_RESULT_ADDR) begin
                r_data <= width32 ? crc_view : {16'h0000, crc_view[15:0]};
            end else if (s_axi_araddr == `CSE_AUTO_ADDR) begin
                r_data <= {16'h0000, 2'h0, blocks_left, 2'h0, block_base};
            end else if (s_axi_araddr == `CSE_DATA_ADDR) begin
                r_data <= 32'h00000000;
            end else begin
                r_data <= 32'h00000000;
                r_resp <= `CSE_RESP_SLVERR;
            end
        end
    end
    // Flash reader for auto mode
    always @(posedge clk_in) begin
        if (sys_rst_in) begin
            state <= ST_IDLE;
            byte_idx <= 10'h000;
            flash_addr_out <= 16'h0000;
            flash_rd_out <= 1'b0;
            auto_push <= 1'b0;
            auto_byte <= 8'h00;
        end else begin
            if (auto_push && fifo_in_ready) begin
                auto_push <= 1'b0;
            end
            case (state)
                ST_IDLE: begin
                    if (blocks_left != 6'h00) begin
                        state <= ST_REQ; // see R6
                        byte_idx <= 10'h000;
                        flash_addr_out <= {block_base, 10'h000};
                    end
                end
                ST_REQ: begin
                    if (!auto_push) begin
                        flash_rd_out <= 1'b1;
                        state <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (flash_ack_in) begin
                        flash_rd_out <= 1'b0;
                        auto_push <= 1'b1;
                        auto_byte <= flash_data_in;
                        flash_addr_out <= flash_addr_out + 16'h0001;
                        byte_idx <= byte_idx + 10'h001;
                        if (byte_idx == 10'h3FF) begin
                            state <= ST_IDLE; // see R6
                        end else begin
                            state <= ST_REQ;
                        end
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end
    assign fifo_in_valid = auto_push | sw_push;
    assign fifo_in_data = auto_push ? auto_byte : sw_byte;
    cse_fifo #(
        .WIDTH(8),
        .DEPTH(`CSE_FIFO_DEPTH),
        .AW(`CSE_FIFO_AW)
    ) u_fifo (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .flush_in(1'b0),
        .in_valid_in(fifo_in_valid),
        .in_ready_out(fifo_in_ready),
        .in_data_in(fifo_in_data),
        .out_valid_out(fifo_out_valid),
        .out_ready_in(1'b1),
        .out_data_out(fifo_out_data)
    );
    // Byte update, MSB first
    generate
        for (g = 0; g < 8; g = g + 1) begin : g_in
            assign in_byte[g] = reverse ? fifo_out_data[7-g]
                : fifo_out_data[g]; // see R7
        end
    endgenerate
    assign poly = width32 ? `CSE_POLY32 : {16'h0000, `CSE_POLY16}; // see R3
    assign seed = seed_ones ? `CSE_SEED_ONES : `CSE_SEED_ZERO;
    always @* begin
        next_crc = crc;
        fb = 1'b0;
        for (i = 7; i >= 0; i = i - 1) begin
            fb = in_byte[i] ^ (width32 ? next_crc[31] : next_crc[15]);
            next_crc = {next_crc[30:0], 1'b0};
            if (fb) begin
                next_crc = next_crc ^ poly; // see R4
            end
        end
        if (!width32) begin
            next_crc = {16'h0000, next_crc[15:0]}; // see R1
        end
    end
    always @(posedge clk_in) begin
        if (sys_rst_in) begin
            crc <= `CSE_SEED_ZERO;
        end else if (init_req) begin
            crc <= width32 ? seed : {16'h0000, seed[15:0]}; // see R5
        end else if (fifo_out_valid) begin
            crc <= next_crc; // see R2
        end
    end
endmodule // cse_checksum_unit

/* File: bench/cse_flash_model.sv */
// Flash reader model answering byte reads after a random delay
`timescale 1ns/10ps
module cse_flash_model (
    input wire clk_in,
    input wire sys_rst_in,
    input wire [15:0] flash_addr_out,
    input wire flash_rd_out,
    output logic [7:0] flash_data_in,
    output logic flash_ack_in
);
    int seed = 32'h2C5E19A7;
    always @(posedge clk_in) begin
        if (sys_rst_in) begin
            flash_ack_in <= 1'b0;
            flash_data_in <= 8'hA5;
        end else if (!flash_ack_in && flash_rd_out &&
                !($random(seed) & 3)) begin
            flash_ack_in <= 1'b1;
            flash_data_in <= flash_addr_out[7:0] ^ flash_addr_out[15:8] ^ 8'h5A;
        end else begin
            flash_ack_in <= 1'b0;
            flash_data_in <= ~flash_data_in;
        end
    end
endmodule // cse_flash_model

/* File: bench/cse_checksum_unit_chk.sv */
// Port checker for the checksum unit
`timescale 1ns/10ps
module cse_checksum_unit_chk (
    input wire clk_in,
    input wire sys_rst_in,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire [15:0] flash_addr_out,
    input wire flash_rd_out,
    input wire flash_ack_in
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);
    chk_write_answer: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##2 s_axi_bvalid) else $error("no bvalid");
    chk_b_single: assert property (s_axi_bvalid && s_axi_bready |=>
        !s_axi_bvalid) else $error("bvalid repeated");
    chk_read_answer: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("no rvalid");
    chk_r_single: assert property (s_axi_rvalid && s_axi_rready |=>
        !s_axi_rvalid) else $error("rvalid repeated");
    chk_ar_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while busy");
    chk_flash_hold: assert property (
        flash_rd_out && !flash_ack_in |=>
        flash_rd_out && $stable(flash_addr_out)) else $error("read dropped");
    chk_flash_gap: assert property (flash_rd_out && flash_ack_in |=>
        !flash_rd_out) else $error("no idle cycle");
    chk_flash_step: assert property (flash_rd_out && flash_ack_in &&
        flash_addr_out[9:0] != 10'h3FF |=>
        flash_addr_out == $past(flash_addr_out) + 16'h0001)
        else $error("address not stepped");
endmodule // cse_checksum_unit_chk
bind cse_checksum_unit cse_checksum_unit_chk chk_i (.*);

/* File: bench/cse_checksum_unit_tb_top.sv */
// Self-checking bench for the checksum unit
`timescale 1ns/10ps
`include "cse_regs.vh"
module cse_checksum_unit_tb_top;
    logic clk_in, sys_rst_in, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
    logic s_axi_arready, s_axi_rvalid, s_axi_rready, flash_rd_out;
    logic flash_ack_in;
    logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [15:0] flash_addr_out;
    logic [7:0] flash_data_in;
    int miscompares, samples_checked;
    logic [1:0] rresp_seen;
    int seed = 32'hd049e3d3;
    cse_checksum_unit dut (.*);
    cse_flash_model flash_i (.*);
    initial begin
        clk_in = 1'b0;
        forever #50 clk_in = ~clk_in;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d,
        output logic [1:0] r);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge clk_in);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge clk_in);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        rresp_seen = s_axi_rresp;
    endtask
    task automatic wait_idle;
        logic [31:0] v;
        repeat (4) @(posedge clk_in);
        do begin
            rd(`CSE_CTRL_ADDR, v);
        end while (v[`CSE_CTRL_BUSY_BIT] !== 1'b0);
    endtask
    task automatic do_reset;
        sys_rst_in <= 1'b1;
        repeat (5) @(posedge clk_in);
        sys_rst_in <= 1'b0;
    endtask
    function automatic logic [7:0] rev8(input logic [7:0] b);
        for (int i = 0; i < 8; i++) rev8[i] = b[7-i];
    endfunction
    function automatic logic [31:0] upd(input logic [31:0] c,
        input logic [7:0] b, input bit w, input bit r);
        b = r ? rev8(b) : b;
        if (w) begin
            c[31:24] = c[31:24] ^ b;
            repeat (8) c = (c << 1) ^ (c[31] ? `CSE_POLY32 : 32'h0);
        end else begin
            c[15:8] = c[15:8] ^ b;
            repeat (8) c[15:0] = (c[15:0] << 1)
                ^ (c[15] ? `CSE_POLY16 : 16'h0);
        end
        return c;
    endfunction
    function automatic logic [31:0] view(input logic [31:0] c, input bit r);
        return r ? {rev8(c[31:24]), rev8(c[23:16]), rev8(c[15:8]),
            rev8(c[7:0])} : c;
    endfunction
    task automatic print_verdict;
        if (miscompares == 0 && samples_checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        logic [31:0] v, e;
        logic [1:0] r;
        logic [7:0] b;
        int n;
        {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} <= 3'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= 40'h0;
        {s_axi_wstrb, s_axi_bready, s_axi_rready} <= 6'h3F;
        do_reset;
        @(posedge clk_in);
        rd(`CSE_CTRL_ADDR, v);
        chk(v, 32'h0);
        rd(4'h2, v);
        chk(v, 32'h0);
        chk(rresp_seen, `CSE_RESP_SLVERR);
        wr(4'h2, 32'h0, r);
        chk(r, `CSE_RESP_SLVERR);
        for (int m = 0; m < 8; m++) begin
            wr(`CSE_CTRL_ADDR, 32'h8 | m, r);
            e = m[1] ? (m[0] ? 32'hFFFFFFFF : 32'h0000FFFF) : 32'h0;
            wait_idle;
            rd(`CSE_RESULT_ADDR, v);
            chk(v, e);
            repeat (1 + ($random(seed) & 7)) begin
                b = $random(seed);
                n = 0;
                do begin
                    wr(`CSE_DATA_ADDR, {24'h0, b}, r);
                    n++;
                end while (r === `CSE_RESP_SLVERR && n < 50);
                chk(r, `CSE_RESP_OKAY);
                e = upd(e, b, m[0], m[2]);
            end
            wait_idle;
            rd(`CSE_RESULT_ADDR, v);
            chk(v, view(e, m[2]));
        end
        wr(`CSE_CTRL_ADDR, 32'hB, r);
        wait_idle;
        wr(`CSE_AUTO_ADDR, 32'h0203, r);
        repeat (2) @(posedge clk_in);
        wr(`CSE_CTRL_ADDR, 32'h0, r);
        chk(r, `CSE_RESP_OKAY);
        wr(`CSE_DATA_ADDR, 32'h55, r);
        chk(r, `CSE_RESP_SLVERR);
        e = 32'hFFFFFFFF;
        for (int a = 3072; a < 5120; a++) begin
            e = upd(e, a[7:0] ^ a[15:8] ^ 8'h5A, 1'b1, 1'b0);
        end
        wait_idle;
        rd(`CSE_RESULT_ADDR, v);
        chk(v, e);
        chk(rresp_seen, `CSE_RESP_OKAY);
        rd(`CSE_AUTO_ADDR, v);
        chk(v[13:8], 32'h0);
        do_reset;
        @(posedge clk_in);
        rd(`CSE_RESULT_ADDR, v);
        chk(v, 32'h0);
        print_verdict;
    end
    initial begin
        #(80000 * 100);
        miscompares++;
        print_verdict;
    end
endmodule // cse_checksum_unit_tb_top
